// ==== rtl/rsc_reset_source_controller.sv ====
module rsc_reset_source_controller #(
  parameter int unsigned CODE_FAULT_LEN = rsc_pkg::CODE_FAULT_CYCLES,
  parameter int unsigned STARTUP_LEN = rsc_pkg::STARTUP_CYCLES,
  parameter int unsigned BO_FILTER_LEN = rsc_pkg::BO_FILTER_CYCLES
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // external reset pin and supply monitor
  input wire logic extNrstPin,
  input wire logic [4:0] supplyBelowLevel,
  // core side
  input wire logic lowPowerMode,
  input wire logic wdtWarmReset,
  input wire logic wdtCodeFault,
  output logic coreReset,
  output logic sharedPinOutputEnable,
  output logic resetPinSelected,
  output logic brownoutEnabled
);
  rsc_pkg::rsc_seq_t seqReg;
  logic [7:0] pinFuncReg;
  logic [7:0] levelReg;
  logic [3:0] causeReg;
  logic pinPrevReg;
  logic awHeldReg, wHeldReg;
  logic [3:0] awAddrReg;
  logic [7:0] wDataReg;
  logic wStrbReg;
  logic wrFire;
  logic running;
  logic pinFall;
  logic pinCodeBad, levelCodeBad;
  logic pinFaultDone, levelFaultDone;
  logic boRun, boDone, startDone;
  logic [2:0] levelSel;
  logic levelValid;
  logic anyTrigger;
  logic keepPinFunc, keepLevel;

  // ---------------- pin function decode
  assign pinCodeBad = (pinFuncReg != rsc_pkg::PIN_CODE_IO) &&
                      (pinFuncReg != rsc_pkg::PIN_CODE_RESET);
  assign sharedPinOutputEnable = (pinFuncReg == rsc_pkg::PIN_CODE_IO);
  // reset role wins over any other mux setting of the shared pin
  assign resetPinSelected = (pinFuncReg == rsc_pkg::PIN_CODE_RESET);

  // ---------------- brown-out level decode
  always_comb begin
    levelSel = 3'h0;
    levelValid = 1'b1;
    case (levelReg)
      rsc_pkg::LVL_1V7: levelSel = 3'h0;
      rsc_pkg::LVL_1V9: levelSel = 3'h1;
      rsc_pkg::LVL_2V55: levelSel = 3'h2;
      rsc_pkg::LVL_3V15: levelSel = 3'h3;
      rsc_pkg::LVL_3V8: levelSel = 3'h4;
      default: levelValid = 1'b0;
    endcase
  end
  assign levelCodeBad = !levelValid && (levelReg != rsc_pkg::LVL_OFF);
  assign brownoutEnabled = levelValid && !lowPowerMode;
  assign running = (seqReg == rsc_pkg::RSC_RUN);
  assign boRun = brownoutEnabled && running && supplyBelowLevel[levelSel];

  // ---------------- delay counters
  rsc_delay_counter #(.LEN(CODE_FAULT_LEN)) u_pin_fault (
    .mclk(mclk),
    .rst(rst),
    .run(pinCodeBad && running),
    .done(pinFaultDone)
  );
  rsc_delay_counter #(.LEN(CODE_FAULT_LEN)) u_level_fault (
    .mclk(mclk),
    .rst(rst),
    .run(levelCodeBad && running),
    .done(levelFaultDone)
  );
  rsc_delay_counter #(.LEN(BO_FILTER_LEN)) u_bo_filter (
    .mclk(mclk),
    .rst(rst),
    .run(boRun),
    .done(boDone)
  );
  rsc_delay_counter #(.LEN(STARTUP_LEN)) u_startup (
    .mclk(mclk),
    .rst(rst),
    .run(seqReg == rsc_pkg::RSC_START),
    .done(startDone)
  );

  // ---------------- reset sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinPrevReg <= 1'b1;
    end else begin
      pinPrevReg <= extNrstPin;
    end
  end
  assign pinFall = pinPrevReg && !extNrstPin && resetPinSelected;
  assign anyTrigger = pinFaultDone || levelFaultDone || boDone || wdtWarmReset;

  always_ff @(posedge mclk) begin
    if (rst) begin
      seqReg <= rsc_pkg::RSC_START;
    end else begin
      case (seqReg)
        rsc_pkg::RSC_RUN: begin
          if (pinFall) begin
            seqReg <= rsc_pkg::RSC_HOLD;
          end else if (anyTrigger) begin
            seqReg <= rsc_pkg::RSC_START;
          end
        end
        rsc_pkg::RSC_HOLD: begin
          if (extNrstPin) begin
            seqReg <= rsc_pkg::RSC_START;
          end
        end
        rsc_pkg::RSC_START: begin
          if (startDone) begin
            seqReg <= rsc_pkg::RSC_RUN;
          end
        end
        default: seqReg <= rsc_pkg::RSC_START;
      endcase
    end
  end
  // core holds pc at zero and ports at all ones while this is high
  assign coreReset = !running;

  // ---------------- axi4-lite write path
  assign awready = !awHeldReg;
  assign wready = !wHeldReg;
  assign wrFire = awHeldReg && wHeldReg && !bvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeldReg <= 1'b0;
      awAddrReg <= 4'h0;
    end else if (awvalid && awready) begin
      awHeldReg <= 1'b1;
      awAddrReg <= awaddr;
    end else if (wrFire) begin
      awHeldReg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wHeldReg <= 1'b0;
      wDataReg <= 8'h00;
      wStrbReg <= 1'b0;
    end else if (wvalid && wready) begin
      wHeldReg <= 1'b1;
      wDataReg <= wdata[7:0];
      wStrbReg <= wstrb[0];
    end else if (wrFire) begin
      wHeldReg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= rsc_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= (awAddrReg == rsc_pkg::OFS_STATUS || awAddrReg[1:0] != 2'b00 ||
                awAddrReg > rsc_pkg::OFS_STATUS) ? rsc_pkg::RESP_DECERR : rsc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------- control registers
  // watchdog warm reset leaves the pin function alone; brown-out leaves the level
  assign keepPinFunc = wdtWarmReset && !pinFall && !pinFaultDone && !levelFaultDone &&
                       !boDone;
  assign keepLevel = (boDone || wdtWarmReset) && !pinFall && !pinFaultDone &&
                     !levelFaultDone;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pinFuncReg <= rsc_pkg::PIN_FUNC_POR;
    end else if (running && (pinFall || anyTrigger) && !keepPinFunc) begin
      pinFuncReg <= rsc_pkg::PIN_FUNC_POR;
    end else if (wrFire && wStrbReg && awAddrReg == rsc_pkg::OFS_PIN_FUNC) begin
      pinFuncReg <= wDataReg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      levelReg <= rsc_pkg::LEVEL_POR;
    end else if (running && (pinFall || anyTrigger) && !keepLevel) begin
      levelReg <= rsc_pkg::LEVEL_POR;
    end else if (wrFire && wStrbReg && awAddrReg == rsc_pkg::OFS_LEVEL) begin
      levelReg <= wDataReg;
    end
  end

  // sticky causes: a set in the same cycle as a software clear wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      causeReg <= rsc_pkg::CAUSE_POR;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wrFire && wStrbReg && awAddrReg == rsc_pkg::OFS_CAUSE && !wDataReg[i]) begin
          causeReg[i] <= 1'b0;
        end
      end
      if (running && pinFaultDone) begin
        causeReg[rsc_pkg::CAUSE_PIN_FAULT] <= 1'b1;
      end
      if (running && boDone) begin
        causeReg[rsc_pkg::CAUSE_LOW_VOLT] <= 1'b1;
      end
      if (running && levelFaultDone) begin
        causeReg[rsc_pkg::CAUSE_LEVEL_FAULT] <= 1'b1;
      end
      if (wdtCodeFault) begin
        causeReg[rsc_pkg::CAUSE_WDT_FAULT] <= 1'b1;
      end
    end
  end

  // ---------------- axi4-lite read path
  assign arready = !rvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rsc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= rsc_pkg::RESP_OKAY;
      case (araddr)
        rsc_pkg::OFS_PIN_FUNC: rdata <= {24'h00_0000, pinFuncReg};
        rsc_pkg::OFS_CAUSE: rdata <= {28'h000_0000, causeReg};
        rsc_pkg::OFS_LEVEL: rdata <= {24'h00_0000, levelReg};
        rsc_pkg::OFS_STATUS: rdata <= {27'h000_0000, brownoutEnabled, resetPinSelected,
                                       sharedPinOutputEnable, seqReg};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= rsc_pkg::RESP_DECERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- checks
  a_pin_fall_reset: assert property (@(posedge mclk) disable iff (rst)
    running && pinFall |=> coreReset && seqReg == rsc_pkg::RSC_HOLD)
    else $error("pin fall did not reset core");
  a_pin_low_hold: assert property (@(posedge mclk) disable iff (rst)
    seqReg == rsc_pkg::RSC_HOLD && !extNrstPin |=> seqReg == rsc_pkg::RSC_HOLD)
    else $error("core left hold while pin low");
  a_pin_enable_map: assert property (@(posedge mclk) disable iff (rst)
    pinFuncReg == rsc_pkg::PIN_CODE_RESET |-> !sharedPinOutputEnable && resetPinSelected)
    else $error("reset code did not clear enable");
  a_pin_fault_flag: assert property (@(posedge mclk) disable iff (rst)
    running && pinFaultDone |=> causeReg[3] && seqReg == rsc_pkg::RSC_START &&
    pinFuncReg == rsc_pkg::PIN_FUNC_POR)
    else $error("pin code fault not handled");
  a_pin_fault_delay: assert property (@(posedge mclk) disable iff (rst)
    pinFaultDone |-> $past(pinCodeBad) && $past(running))
    else $error("pin fault fired without cause");
  a_cause_high_zero: assert property (@(posedge mclk) disable iff (rst)
    rvalid && $past(araddr) == rsc_pkg::OFS_CAUSE && $past(arvalid && arready)
    |-> rdata[31:4] == 28'h000_0000)
    else $error("cause upper bits not zero");
  a_bo_keep_level: assert property (@(posedge mclk) disable iff (rst)
    running && boDone && !pinFall && !pinFaultDone && !levelFaultDone
    |=> levelReg == $past(levelReg) && causeReg[2])
    else $error("brown-out changed level register");
  a_level_restore: assert property (@(posedge mclk) disable iff (rst)
    running && levelFaultDone |=> levelReg == rsc_pkg::LEVEL_POR && causeReg[1])
    else $error("level fault not restored");
  a_sleep_off: assert property (@(posedge mclk) disable iff (rst)
    lowPowerMode |-> !boRun && !brownoutEnabled)
    else $error("monitor active in low power");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
    causeReg[2] && !(wrFire && awAddrReg == rsc_pkg::OFS_CAUSE) |=> causeReg[2])
    else $error("low voltage flag lost");
endmodule

// ==== rtl/rsc_pkg.sv ====
package rsc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_PIN_FUNC = 4'h0;
  localparam logic [3:0] OFS_CAUSE = 4'h4;
  localparam logic [3:0] OFS_LEVEL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // pin function codes
  localparam logic [7:0] PIN_CODE_IO = 8'h55;
  localparam logic [7:0] PIN_CODE_RESET = 8'hAA;
  localparam logic [7:0] PIN_FUNC_POR = 8'hAA;

  // brown-out level codes
  localparam logic [7:0] LVL_1V7 = 8'h66;
  localparam logic [7:0] LVL_1V9 = 8'h55;
  localparam logic [7:0] LVL_2V55 = 8'h33;
  localparam logic [7:0] LVL_3V15 = 8'h99;
  localparam logic [7:0] LVL_3V8 = 8'hAA;
  localparam logic [7:0] LVL_OFF = 8'hF0;
  localparam logic [7:0] LEVEL_POR = 8'h66;

  // reset cause flag positions
  localparam int CAUSE_PIN_FAULT = 3;
  localparam int CAUSE_LOW_VOLT = 2;
  localparam int CAUSE_LEVEL_FAULT = 1;
  localparam int CAUSE_WDT_FAULT = 0;
  localparam logic [3:0] CAUSE_POR = 4'h0;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CODE_FAULT_DELAY_NS = 45000;
  localparam int unsigned STARTUP_DELAY_NS = 1000000;
  localparam int unsigned BO_FILTER_TIME_NS = 120000;
  localparam int unsigned CODE_FAULT_CYCLES =
    (CODE_FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYCLES =
    (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BO_FILTER_CYCLES =
    (BO_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    RSC_RUN = 2'b00,
    RSC_HOLD = 2'b01,
    RSC_START = 2'b10
  } rsc_seq_t;
endpackage

// ==== rtl/rsc_delay_counter.sv ====
module rsc_delay_counter #(
  parameter int unsigned LEN = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic run,
  output logic done
);
  localparam int CW = (LEN > 1) ? $clog2(LEN) : 1;

  logic [CW-1:0] countReg;

  // restarts from zero whenever run drops, so short dips are forgotten
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      countReg <= '0;
    end else if (!done) begin
      countReg <= countReg + 1'b1;
    end
  end

  assign done = run && (countReg == CW'(LEN - 1));
endmodule

// ==== test/rsc_ext_reset_model.sv ====
module rsc_ext_reset_model (
  // clock
  input wire logic mclk,
  // request from bench
  input wire logic pressReq,
  input wire logic [7:0] holdLen,
  // pin, pulled up when released
  output logic extNrstPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] holdCnt;
  initial begin
    extNrstPin = 1'h1;
    holdCnt = 8'h00;
  end
  // rc network: low for holdLen cycles, then the pull-up wins
  always @(posedge mclk) begin
    if (holdCnt != 8'h00) begin
      holdCnt <= holdCnt - 8'h01;
      if (holdCnt == 8'h01) extNrstPin <= 1'h1;
    end else if (pressReq) begin
      extNrstPin <= 1'h0;
      // a zero length would leave the pin low for good
      holdCnt <= (holdLen == 8'h00) ? 8'h01 : holdLen;
    end
  end
endmodule

// ==== test/reset_source_controller_tb.sv ====
module reset_source_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CF = 4;
  localparam int SU = 8;
  localparam int BO = 6;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, extNrstPin, lowPowerMode, wdtWarmReset, wdtCodeFault, pressReq;
  logic coreReset, sharedPinOutputEnable, resetPinSelected, brownoutEnabled;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] supplyBelowLevel;
  logic [7:0] holdLen, code;
  logic [33:0] e;
  logic [33:0] expQ[$];
  logic [7:0] lvls[5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA};
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hc53d;
  rsc_reset_source_controller #(.CODE_FAULT_LEN(CF), .STARTUP_LEN(SU), .BO_FILTER_LEN(BO)) dut (
    .mclk(mclk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .extNrstPin(extNrstPin),
    .supplyBelowLevel(supplyBelowLevel), .lowPowerMode(lowPowerMode),
    .wdtWarmReset(wdtWarmReset), .wdtCodeFault(wdtCodeFault), .coreReset(coreReset),
    .sharedPinOutputEnable(sharedPinOutputEnable), .resetPinSelected(resetPinSelected),
    .brownoutEnabled(brownoutEnabled));
  rsc_ext_reset_model partner (.mclk(mclk), .pressReq(pressReq), .holdLen(holdLen),
    .extNrstPin(extNrstPin));
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] resp = 2'h0, input logic [3:0] s = 4'hF);
    expQ.push_back({resp, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    // bready stays high afterwards, so a following call only rewrites it with the same value
    end while (!(bvalid && bready));
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] resp = 2'h0);
    expQ.push_back({resp, 24'h0, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
  endtask
  // counts edges until coreReset reaches lvl; passes if the count lies in [lo, hi]
  task automatic waitCore(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (coreReset !== lvl && n < hi + 5) begin
      @(posedge mclk);
      n++;
    end
    chk({33'h0, n >= lo && n <= hi}, 34'h1);
  endtask
  task automatic press(input logic [7:0] len);
    holdLen <= len;
    pressReq <= 1'h1;
    @(posedge mclk);
    pressReq <= 1'h0;
  endtask
  // a single queue is enough: one transfer is under way at a time
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      e = expQ.pop_front();
      if (e[33:32] == rsc_pkg::RESP_DECERR) chk({rresp, 32'h0}, {e[33:32], 32'h0});
      else chk({rresp, rdata}, e);
    end
    if (bvalid && bready) begin
      e = expQ.pop_front();
      chk({bresp, 32'h0}, e);
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F & 6'h20;
    {lowPowerMode, wdtWarmReset, wdtCodeFault, pressReq} = 4'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    supplyBelowLevel = 5'h00;
    holdLen = 8'h00;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    chk({33'h0, coreReset}, 34'h1);
    waitCore(1'h0, SU - 1, SU + 3);
    rd(4'h0, 8'hAA);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h66);
    rd(4'hC, 8'h18);
    rd(4'h6, 8'h00, rsc_pkg::RESP_DECERR);
    wr(4'hC, 8'h00, rsc_pkg::RESP_DECERR);
    wr(4'h0, 8'h55);
    chk({32'h0, sharedPinOutputEnable, resetPinSelected}, 34'h2);
    wr(4'h0, 8'hAA, 2'h0, 4'h0);
    press(8'h04);
    repeat (6) @(posedge mclk);
    chk({32'h0, sharedPinOutputEnable, coreReset}, 34'h2);
    wr(4'h0, 8'hAA);
    chk({32'h0, sharedPinOutputEnable, resetPinSelected}, 34'h1);
    press(8'h0C);
    repeat (3) @(posedge mclk);
    chk({33'h0, coreReset}, 34'h1);
    repeat (8) @(posedge mclk);
    chk({33'h0, coreReset}, 34'h1);
    waitCore(1'h0, SU, SU + 4);
    repeat (2) begin
      do code = 8'($random(seed)); while (code inside {8'h55, 8'hAA});
      wr(4'h0, code);
      waitCore(1'h1, CF - 1, CF + 3);
      waitCore(1'h0, SU - 1, SU + 3);
      rd(4'h4, 8'h08);
      rd(4'h0, 8'hAA);
      wr(4'h4, 8'hFF);
      rd(4'h4, 8'h08);
      wr(4'h4, 8'h00);
      rd(4'h4, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      wr(4'h8, lvls[i]);
      wr(4'h0, 8'h55);
      supplyBelowLevel[i] <= 1'h1;
      repeat (BO - 2) @(posedge mclk);
      supplyBelowLevel[i] <= 1'h0;
      repeat (3) @(posedge mclk);
      chk({32'h0, brownoutEnabled, coreReset}, 34'h2);
      supplyBelowLevel[i] <= 1'h1;
      waitCore(1'h1, BO - 1, BO + 3);
      supplyBelowLevel[i] <= 1'h0;
      waitCore(1'h0, SU - 1, SU + 3);
      rd(4'h4, 8'h04);
      rd(4'h8, lvls[i]);
      rd(4'h0, 8'hAA);
      wr(4'h4, 8'hFF);
      rd(4'h4, 8'h04);
      wr(4'h4, 8'h00);
    end
    wr(4'h8, 8'hF0);
    supplyBelowLevel <= 5'h1F;
    repeat (BO + 4) @(posedge mclk);
    chk({32'h0, brownoutEnabled, coreReset}, 34'h0);
    wr(4'h8, 8'h66);
    lowPowerMode <= 1'h1;
    repeat (BO + 4) @(posedge mclk);
    chk({32'h0, brownoutEnabled, coreReset}, 34'h0);
    supplyBelowLevel <= 5'h00;
    lowPowerMode <= 1'h0;
    do code = 8'($random(seed)); while (code inside {8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0});
    wr(4'h0, 8'h55);
    wr(4'h8, code);
    waitCore(1'h1, CF - 1, CF + 3);
    waitCore(1'h0, SU - 1, SU + 3);
    rd(4'h4, 8'h02);
    rd(4'h8, 8'h66);
    rd(4'h0, 8'hAA);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h55);
    wr(4'h8, 8'h33);
    wdtWarmReset <= 1'h1;
    @(posedge mclk);
    wdtWarmReset <= 1'h0;
    waitCore(1'h1, 0, 3);
    waitCore(1'h0, SU - 1, SU + 3);
    rd(4'h0, 8'h55);
    rd(4'h8, 8'h33);
    wdtCodeFault <= 1'h1;
    @(posedge mclk);
    wdtCodeFault <= 1'h0;
    rd(4'h4, 8'h01);
    results();
  end
endmodule
